// file: bridge_checker_sva.sv
module bridge_checker #(
    parameter int FILTER_CYCLES = 30,
    parameter int STUCK_CYCLES = 200
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic vcc_ok,
    input wire logic over_temp,
    input wire bridge_pkg::line_cmp_type sda_cmp,
    input wire bridge_pkg::line_cmp_type scl_cmp,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic [1:0] limiter_en,
    input wire logic [1:0] edge_pullup_assist,
    input wire logic ready_out,
    input wire logic ready_oe,
    input wire logic shutdown,
    input wire logic tx_pos,
    input wire logic tx_neg
);
    import bridge_pkg::*;
    // ==========
    // run, stop and low-line counters
    // ==========
    int up_q;
    int off_q;
    int low_q;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            up_q <= 0;
            off_q <= 0;
            low_q <= 0;
        end else begin
            up_q <= (shutdown || over_temp || !vcc_ok) ? 0 : up_q + 1;
            off_q <= shutdown ? off_q + 1 : 0;
            low_q <= (sda_cmp.level && scl_cmp.level) ? 0 : low_q + 1;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // ==========
    // properties
    // ==========
    a_pins_open_drain: assert property (!sda_out && !scl_out && !ready_out)
        else $error("pin driven high");
    a_drive_needs_link: assert property ((sda_oe || scl_oe) |-> ready_oe)
        else $error("line driven while not linked");
    a_link_after_filter: assert property ($rose(ready_oe) |-> up_q >= FILTER_CYCLES)
        else $error("linked before filter time");
    a_stuck_drops_ready: assert property (low_q > STUCK_CYCLES + 8 |-> !ready_oe && !sda_oe && !scl_oe)
        else $error("stuck bus still linked");
    a_off_releases: assert property (shutdown [*3] |-> !ready_oe && !sda_oe && !scl_oe && edge_pullup_assist == 2'h0)
        else $error("shutdown with pins active");
    // a message in flight may finish, so allow well over one frame
    a_off_no_tx: assert property (off_q > 150 |-> !tx_pos && !tx_neg)
        else $error("transmit during shutdown");
    a_tx_pair_apart: assert property (!(tx_pos && tx_neg))
        else $error("both transmit pulses at once");
    a_limit_before_assist: assert property (limiter_en[0] |-> !edge_pullup_assist[0])
        else $error("assist with limiter on");
    c_linked: cover property ($rose(ready_oe));
    c_drive: cover property ($rose(sda_oe));
    c_stuck: cover property (low_q == STUCK_CYCLES + 9);
endmodule : bridge_checker

bind isolated_i2c_link_bridge bridge_checker #(.FILTER_CYCLES(FILTER_CYCLES), .STUCK_CYCLES(STUCK_CYCLES))
    i_bridge_checker (.sys_clk, .rst_n, .vcc_ok, .over_temp, .sda_cmp, .scl_cmp, .sda_out, .sda_oe, .scl_out,
    .scl_oe, .limiter_en, .edge_pullup_assist, .ready_out, .ready_oe, .shutdown, .tx_pos, .tx_neg);

// file: bridge_pkg.sv
package bridge_pkg;

    // ==========================================================
    // clock and timing
    // ==========================================================
    localparam int CLK_MHZ = 100;
    localparam int IDLE_US = 115;
    localparam int FILTER_US = 900;
    localparam int STUCK_MS = 37;
    localparam real RETX_MS = 1.15;
    localparam int BOOST_NS = 300;
    localparam int IDLE_CYC = IDLE_US * CLK_MHZ;
    localparam int FILTER_CYC = FILTER_US * CLK_MHZ;
    localparam int STUCK_CYC = STUCK_MS * 1000 * CLK_MHZ;
    localparam int RETX_CYC = $rtoi(RETX_MS * 1000.0 * CLK_MHZ);
    // longest time, so rounded down
    localparam int BOOST_CYC = (BOOST_NS * CLK_MHZ) / 1000;

    // ==========================================================
    // line indices and link message
    // ==========================================================
    localparam int LINE_SDA = 0;
    localparam int LINE_SCL = 1;
    localparam int MSG_W = 3;
    localparam int GAP_CYC = 3;

    typedef struct packed {
        logic stuck;
        logic scl_hi;
        logic sda_hi;
    } link_msg_type;

    localparam link_msg_type MSG_IDLE = 3'h3;

    // comparator outputs of one bus line
    typedef struct packed {
        logic level;
        logic fall_det;
        logic rising;
        logic above_low;
        logic above_high;
        logic below_reg;
        logic rate_slow;
    } line_cmp_type;

    localparam int CMP_W = 7;

    // ==========================================================
    // connection states, gray along the usual path
    // ==========================================================
    typedef enum logic [2:0] {
        ST_POR = 3'h0,
        ST_FILTER = 3'h1,
        ST_WAIT = 3'h3,
        ST_LINKED = 3'h2,
        ST_STUCK = 3'h6
    } link_state_type;

endpackage : bridge_pkg

// file: isolated_i2c_link_bridge.sv
// Behaviour
// - enable high runs the link; enable low stops it and signals shutdown
// - ready pin pulled low only while local lines mirror the partner
// - tell external drive from own drive, send it, drive from received state
// - external sda fall below detect level sends a pull-low message
// - external pull below regulated low while we hold sda sends low at once
// - released line rising under the limiter sends a high state
// - rise rate too slow counts as a new pull-down, sends low
// - limiter off past lower threshold, edge assist on past higher one
// - held in reset with pins released until enable, no overheat, supply good
// - overheat keeps the block in reset with pins released
// - after reset watch local and partner bus for stop or idle
// - drivers, detection, assist and ready only on quiet on both buses
// - bus low for stuck time disables drivers, detection and assist
// - stuck bus releases the ready pin
// - after a stuck bus frees, reconnect only on quiet on both buses
// - mirroring keeps stretching, synchronisation, arbitration and acknowledge
// - idle means both high for idle time, or stop seen and high since
// - stuck timer runs while any line low, clears when both high, at the stuck time, or in reset or stuck state
// - receive stays off for the filter time after reset, transmit runs
// - resend the line state when nothing changed for the resend time
module isolated_i2c_link_bridge #(
    parameter int IDLE_CYCLES = bridge_pkg::IDLE_CYC,
    parameter int FILTER_CYCLES = bridge_pkg::FILTER_CYC,
    parameter int STUCK_CYCLES = bridge_pkg::STUCK_CYC,
    parameter int RETX_CYCLES = bridge_pkg::RETX_CYC
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic link_clk,
    input wire logic enable,
    input wire logic vcc_ok,
    input wire logic over_temp,
    input wire bridge_pkg::line_cmp_type sda_cmp,
    input wire bridge_pkg::line_cmp_type scl_cmp,
    output logic sda_out,
    output logic sda_oe,
    output logic scl_out,
    output logic scl_oe,
    output logic [1:0] limiter_en,
    output logic [1:0] edge_pullup_assist,
    output logic ready_out,
    output logic ready_oe,
    output logic shutdown,
    output logic tx_pos,
    output logic tx_neg,
    input wire logic rx_pos,
    input wire logic rx_neg
);
    import bridge_pkg::*;

    localparam int IDLE_W = $clog2(IDLE_CYCLES + 1);
    localparam int FILT_W = $clog2(FILTER_CYCLES + 1);
    localparam int STUCK_W = $clog2(STUCK_CYCLES + 1);
    localparam int RETX_W = $clog2(RETX_CYCLES + 1);
    localparam int BOOST_W = $clog2(BOOST_CYC + 1);
    localparam int SYNC_W = 2 * CMP_W + 3;

    // ==========================================================
    // input synchronisers
    // ==========================================================
    logic [SYNC_W-1:0] in1_q;
    logic [SYNC_W-1:0] in2_q;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            in1_q <= '0;
            in2_q <= '0;
        end else begin
            in1_q <= {over_temp, vcc_ok, enable, scl_cmp, sda_cmp};
            in2_q <= in1_q;
        end
    end

    line_cmp_type [1:0] cmp;
    wire en_s = in2_q[2*CMP_W];
    wire vcc_s = in2_q[2*CMP_W+1];
    wire hot_s = in2_q[2*CMP_W+2];
    assign cmp = in2_q[2*CMP_W-1:0];

    // leave reset only when all is well
    wire power_good = en_s && vcc_s && !hot_s;

    // ==========================================================
    // link domain handshakes
    // ==========================================================
    logic tx_en_q;
    logic rx_en_q;
    logic tx_req_q;
    link_msg_type tx_msg_q;
    logic tx_ack_tgl;
    logic rx_tgl;
    link_msg_type rx_msg;
    logic [2:0] ack_sync_q;
    logic [2:0] rx_sync_q;

    link_codec u_codec (
        .link_clk(link_clk),
        .rst_n(rst_n),
        .tx_en(tx_en_q),
        .rx_en(rx_en_q),
        .tx_req_tgl(tx_req_q),
        .tx_msg(tx_msg_q),
        .tx_ack_tgl(tx_ack_tgl),
        .rx_tgl(rx_tgl),
        .rx_msg(rx_msg),
        .tx_pos(tx_pos),
        .tx_neg(tx_neg),
        .rx_pos(rx_pos),
        .rx_neg(rx_neg)
    );

    // third stage only feeds the edge compare, never the first stage
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_sync_q <= 3'h0;
            rx_sync_q <= 3'h0;
        end else begin
            ack_sync_q <= {ack_sync_q[1:0], tx_ack_tgl};
            rx_sync_q <= {rx_sync_q[1:0], rx_tgl};
        end
    end

    wire tx_busy = tx_req_q != ack_sync_q[1];
    wire rx_new = rx_sync_q[2] != rx_sync_q[1];

    // ==========================================================
    // connection state
    // ==========================================================
    link_state_type state_q;
    link_state_type state_d;
    link_msg_type remote_q;
    logic [FILT_W-1:0] filt_q;
    logic [STUCK_W-1:0] stuck_q;
    logic [1:0] quiet;
    wire linked = state_q == ST_LINKED;
    wire rx_live = state_q == ST_WAIT || linked || state_q == ST_STUCK;
    wire local_high = cmp[LINE_SDA].level && cmp[LINE_SCL].level;
    wire filt_done = filt_q == FILT_W'(FILTER_CYCLES - 1);
    wire stuck_hit = stuck_q == STUCK_W'(STUCK_CYCLES - 1);
    wire both_quiet = quiet[0] && quiet[1] && !remote_q.stuck;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_POR: begin
                if (power_good) begin
                    state_d = ST_FILTER;
                end
            end
            ST_FILTER: begin
                if (filt_done) begin
                    state_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (stuck_hit) begin
                    state_d = ST_STUCK;
                end else if (both_quiet) begin
                    state_d = ST_LINKED;
                end
            end
            ST_LINKED: begin
                if (stuck_hit) begin
                    state_d = ST_STUCK;
                end else if (remote_q.stuck) begin
                    state_d = ST_WAIT;
                end
            end
            ST_STUCK: begin
                if (local_high) begin
                    state_d = ST_WAIT;
                end
            end
            default: begin
                state_d = ST_POR;
            end
        endcase
        if (!power_good) begin
            state_d = ST_POR;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_POR;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            filt_q <= '0;
        end else if (state_q != ST_FILTER || filt_done) begin
            filt_q <= '0;
        end else begin
            filt_q <= filt_q + FILT_W'(1);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stuck_q <= '0;
        end else if (local_high || state_q == ST_POR || state_q == ST_STUCK || stuck_hit) begin
            stuck_q <= '0;
        end else begin
            stuck_q <= stuck_q + STUCK_W'(1);
        end
    end

    // partner state is all-high until decoding runs
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            remote_q <= MSG_IDLE;
        end else if (!rx_live) begin
            remote_q <= MSG_IDLE;
        end else if (rx_new) begin
            remote_q <= rx_msg;
        end
    end

    // ==========================================================
    // stop and idle detection, local bus 0, partner bus 1
    // ==========================================================
    logic [1:0] bus_sda;
    logic [1:0] bus_scl;
    assign bus_sda = {remote_q.sda_hi, cmp[LINE_SDA].level};
    assign bus_scl = {remote_q.scl_hi, cmp[LINE_SCL].level};

    for (genvar b = 0; b < 2; b++) begin : g_quiet
        logic [IDLE_W-1:0] idle_q;
        logic sda_prev_q;
        logic stop_q;
        wire high = bus_sda[b] && bus_scl[b];
        wire idle_done = idle_q == IDLE_W'(IDLE_CYCLES);
        // stop is sda rising under high scl
        wire stop_evt = !sda_prev_q && bus_sda[b] && bus_scl[b];

        always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                idle_q <= '0;
                sda_prev_q <= 1'b1;
                stop_q <= 1'b0;
            end else begin
                sda_prev_q <= bus_sda[b];
                if (!high || !rx_live) begin
                    idle_q <= '0;
                end else if (!idle_done) begin
                    idle_q <= idle_q + IDLE_W'(1);
                end
                if (stop_evt && rx_live) begin
                    stop_q <= 1'b1;
                end else if (!high || !rx_live) begin
                    stop_q <= 1'b0;
                end
            end
        end

        assign quiet[b] = idle_done || (stop_q && high);
    end

    // ==========================================================
    // per line logic detection and edge control
    // ==========================================================
    logic [1:0] drive_q;
    logic [1:0] ext_low;
    logic [1:0] remote_hi;
    assign remote_hi = {remote_q.scl_hi, remote_q.sda_hi};

    for (genvar i = 0; i < 2; i++) begin : g_line
        logic limit_q;
        logic armed_q;
        logic assist_q;
        logic [BOOST_W-1:0] boost_q;
        // slow rise is a new pull-down
        wire undriven_low = cmp[i].fall_det && !(cmp[i].rising && !cmp[i].rate_slow);
        wire driven_low = cmp[i].below_reg;
        wire limit_on = linked && !drive_q[i] && cmp[i].rising && !cmp[i].above_low && !cmp[i].rate_slow;
        wire boost_go = linked && armed_q && cmp[i].above_high && !limit_q;
        wire boost_end = boost_q == BOOST_W'(BOOST_CYC - 1);

        assign ext_low[i] = linked ? (drive_q[i] ? driven_low : undriven_low) : !cmp[i].level;

        always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                limit_q <= 1'b0;
                armed_q <= 1'b0;
                boost_q <= '0;
                assist_q <= 1'b0;
            end else begin
                limit_q <= limit_on;
                assist_q <= linked && !boost_end && (boost_q != '0 || boost_go);
                if (!linked || boost_end) begin
                    boost_q <= '0;
                end else if (boost_q != '0 || boost_go) begin
                    boost_q <= boost_q + BOOST_W'(1);
                end
                if (cmp[i].fall_det && !cmp[i].above_high) begin
                    armed_q <= 1'b1;
                end else if (boost_go) begin
                    armed_q <= 1'b0;
                end
            end
        end

        // assist cut after a fixed burst so it never fights the next fall
        assign limiter_en[i] = limit_q;
        assign edge_pullup_assist[i] = assist_q;
    end

    // ==========================================================
    // pins
    // ==========================================================
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            drive_q <= 2'h0;
            sda_out <= 1'b0;
            scl_out <= 1'b0;
            ready_out <= 1'b0;
            ready_oe <= 1'b0;
            shutdown <= 1'b1;
            tx_en_q <= 1'b0;
            rx_en_q <= 1'b0;
        end else begin
            // mirror partner lows, any side may stretch or win
            drive_q <= (state_d == ST_LINKED) ? ~remote_hi : 2'h0;
            sda_out <= 1'b0;
            scl_out <= 1'b0;
            ready_out <= 1'b0;
            ready_oe <= state_d == ST_LINKED;
            shutdown <= !en_s;
            tx_en_q <= state_d != ST_POR;
            rx_en_q <= state_d == ST_WAIT || state_d == ST_LINKED || state_d == ST_STUCK;
        end
    end

    assign sda_oe = drive_q[LINE_SDA];
    assign scl_oe = drive_q[LINE_SCL];

    // ==========================================================
    // transmit on change or on resend timeout
    // ==========================================================
    logic [RETX_W-1:0] retx_q;
    link_msg_type sent_q;
    link_msg_type cur_msg;
    assign cur_msg = {state_q == ST_STUCK, !ext_low[LINE_SCL], !ext_low[LINE_SDA]};
    wire retx_due = retx_q == RETX_W'(RETX_CYCLES - 1);
    wire send = tx_en_q && !tx_busy && (cur_msg != sent_q || retx_due);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            retx_q <= '0;
            sent_q <= MSG_IDLE;
            tx_msg_q <= MSG_IDLE;
            tx_req_q <= 1'b0;
        end else if (!tx_en_q) begin
            retx_q <= '0;
            sent_q <= ~MSG_IDLE;
        end else if (send) begin
            retx_q <= '0;
            sent_q <= cur_msg;
            tx_msg_q <= cur_msg;
            tx_req_q <= !tx_req_q;
        end else if (!retx_due) begin
            retx_q <= retx_q + RETX_W'(1);
        end
    end

endmodule : isolated_i2c_link_bridge

// file: link_codec.sv
module link_codec (
    input wire logic link_clk,
    input wire logic rst_n,
    input wire logic tx_en,
    input wire logic rx_en,
    input wire logic tx_req_tgl,
    input wire bridge_pkg::link_msg_type tx_msg,
    output logic tx_ack_tgl,
    output logic rx_tgl,
    output bridge_pkg::link_msg_type rx_msg,
    output logic tx_pos,
    output logic tx_neg,
    input wire logic rx_pos,
    input wire logic rx_neg
);
    import bridge_pkg::*;

    // ==========================================================
    // synchronisers
    // ==========================================================
    logic [4:0] sync1_q;
    logic [4:0] sync2_q;
    logic req_seen_q;
    wire tx_en_s = sync2_q[0];
    wire rx_en_s = sync2_q[1];
    wire req_s = sync2_q[2];
    wire rxp_s = sync2_q[3];
    wire rxn_s = sync2_q[4];

    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= 5'h0;
            sync2_q <= 5'h0;
        end else begin
            sync1_q <= {rx_neg, rx_pos, tx_req_tgl, rx_en, tx_en};
            sync2_q <= sync1_q;
        end
    end

    // ==========================================================
    // transmit: each bit is a matched pos/neg pulse pair
    // ==========================================================
    logic [MSG_W-1:0] shift_q;
    logic [1:0] bits_q;
    logic half_q;
    logic busy_q;
    wire start = tx_en_s && !busy_q && (req_s != req_seen_q);
    wire cur_bit = shift_q[MSG_W-1];
    wire last_half = busy_q && half_q && (bits_q == 2'(MSG_W - 1));

    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_q <= '0;
            bits_q <= 2'h0;
            half_q <= 1'b0;
            busy_q <= 1'b0;
            req_seen_q <= 1'b0;
            tx_ack_tgl <= 1'b0;
            tx_pos <= 1'b0;
            tx_neg <= 1'b0;
        end else if (start) begin
            shift_q <= tx_msg;
            bits_q <= 2'h0;
            half_q <= 1'b0;
            busy_q <= 1'b1;
            req_seen_q <= req_s;
            tx_pos <= 1'b0;
            tx_neg <= 1'b0;
        end else if (busy_q) begin
            tx_pos <= half_q ? !cur_bit : cur_bit;
            tx_neg <= half_q ? cur_bit : !cur_bit;
            half_q <= !half_q;
            if (half_q) begin
                shift_q <= {shift_q[MSG_W-2:0], 1'b0};
                bits_q <= bits_q + 2'h1;
            end
            if (last_half) begin
                busy_q <= 1'b0;
                tx_ack_tgl <= !tx_ack_tgl;
            end
        end else begin
            tx_pos <= 1'b0;
            tx_neg <= 1'b0;
        end
    end

    // ==========================================================
    // receive: first pulse of a pair gives the bit
    // ==========================================================
    logic [MSG_W-1:0] rshift_q;
    logic [1:0] rbits_q;
    logic rhalf_q;
    logic [1:0] gap_q;
    wire pulse = rxp_s || rxn_s;
    wire rdone = pulse && rhalf_q && (rbits_q == 2'(MSG_W - 1));

    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            rshift_q <= '0;
            rbits_q <= 2'h0;
            rhalf_q <= 1'b0;
            gap_q <= 2'h0;
            rx_tgl <= 1'b0;
            rx_msg <= MSG_IDLE;
        end else if (!rx_en_s || (!pulse && gap_q == 2'(GAP_CYC - 1))) begin
            rbits_q <= 2'h0;
            rhalf_q <= 1'b0;
            gap_q <= 2'h0;
        end else if (pulse) begin
            gap_q <= 2'h0;
            rhalf_q <= !rhalf_q;
            if (!rhalf_q) begin
                rshift_q <= {rshift_q[MSG_W-2:0], rxp_s};
            end else begin
                rbits_q <= rdone ? 2'h0 : rbits_q + 2'h1;
            end
            if (rdone) begin
                rx_msg <= rshift_q;
                rx_tgl <= !rx_tgl;
            end
        end else begin
            gap_q <= gap_q + 2'h1;
        end
    end

endmodule : link_codec

// file: remote_isolator.sv
module remote_isolator (
    input wire logic link_clk,
    input wire logic tx_pos,
    input wire logic tx_neg,
    output logic rx_pos,
    output logic rx_neg,
    output bridge_pkg::link_msg_type seen,
    output int seen_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    import bridge_pkg::*;
    logic pos_q = 1'b0;
    logic neg_q = 1'b0;
    link_msg_type seen_q = 3'h0;
    logic [2:0] bits_q = 3'h0;
    int cnt_q = 0;
    int pulse_q = 0;
    int gap_q = 0;
    assign rx_pos = pos_q;
    assign rx_neg = neg_q;
    assign seen = seen_q;
    assign seen_cnt = cnt_q;
    // first pulse of a pair is the bit
    always @(posedge link_clk) begin
        if (tx_pos || tx_neg) begin
            gap_q = 0;
            if (pulse_q % 2 == 0) bits_q = {bits_q[1:0], tx_pos};
            pulse_q++;
            if (pulse_q == 6) begin
                seen_q = bits_q;
                cnt_q++;
                pulse_q = 0;
            end
        end else if (++gap_q >= 3) begin
            pulse_q = 0;
        end
    end
    // pulse pairs msb first, both low when idle
    task automatic send(input link_msg_type m);
        for (int i = 2; i >= 0; i--) begin
            @(posedge link_clk);
            pos_q <= m[i];
            neg_q <= !m[i];
            @(posedge link_clk);
            pos_q <= !m[i];
            neg_q <= m[i];
        end
        @(posedge link_clk);
        pos_q <= 1'b0;
        neg_q <= 1'b0;
        repeat (4) @(posedge link_clk);
    endtask : send
endmodule : remote_isolator

// file: tb_isolated_i2c_link_bridge.sv
module tb_isolated_i2c_link_bridge;
    timeunit 1ns;
    timeprecision 1ps;
    import bridge_pkg::*;
    localparam line_cmp_type HIGH = 7'h4C;
    localparam line_cmp_type LOW = 7'h20;
    logic sys_clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst_n, enable, vcc_ok, over_temp;
    line_cmp_type sda_cmp;
    line_cmp_type scl_cmp;
    logic sda_out, sda_oe, scl_out, scl_oe, ready_out, ready_oe, shutdown, tx_pos, tx_neg, rx_pos, rx_neg;
    logic [1:0] limiter_en;
    logic [1:0] edge_pullup_assist;
    link_msg_type seen;
    int seen_cnt;
    int miscompares = 0;
    int samples_checked = 0;
    always #5 sys_clk = ~sys_clk;
    initial #7 forever #40 link_clk = ~link_clk;
    // short counts keep the run small
    isolated_i2c_link_bridge #(.IDLE_CYCLES(20), .FILTER_CYCLES(30), .STUCK_CYCLES(1000), .RETX_CYCLES(100))
        i_isolated_i2c_link_bridge (.sys_clk, .rst_n, .link_clk, .enable, .vcc_ok, .over_temp, .sda_cmp,
        .scl_cmp, .sda_out, .sda_oe, .scl_out, .scl_oe, .limiter_en, .edge_pullup_assist, .ready_out,
        .ready_oe, .shutdown, .tx_pos, .tx_neg, .rx_pos, .rx_neg);
    remote_isolator i_remote_isolator (.link_clk, .tx_pos(tx_pos), .tx_neg(tx_neg), .rx_pos(rx_pos),
        .rx_neg(rx_neg), .seen(seen), .seen_cnt(seen_cnt));
    // ==========
    // shared tasks
    // ==========
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : test_done
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, got, exp);
        end
    endtask : check
    function automatic logic [7:0] pick(input int sel);
        case (sel)
            0: return {7'h00, ready_oe};
            1: return {7'h00, sda_oe};
            2: return {5'h00, seen};
            default: return {7'h00, shutdown};
        endcase
    endfunction : pick
    task automatic wait_for(input int sel, input logic [7:0] exp);
        int i;
        for (i = 0; i < 2000 && pick(sel) !== exp; i++) begin
            @(posedge sys_clk);
            #1;
        end
        check(pick(sel), exp);
        if (i == 2000) test_done();
    endtask : wait_for
    // partner keeps reporting a quiet bus until we link
    task automatic relink();
        for (int i = 0; i < 30 && ready_oe !== 1'b1; i++) begin
            i_remote_isolator.send(MSG_IDLE);
            repeat (20) @(posedge sys_clk);
            #1;
        end
    endtask : relink
    // ==========
    // scenarios
    // ==========
    task automatic t_link();
        relink();
        wait_for(0, 8'h01);
        wait_for(2, 8'h03);
    endtask : t_link
    task automatic t_remote();
        i_remote_isolator.send(3'h2);
        wait_for(1, 8'h01);
        @(posedge sys_clk) sda_cmp <= 7'h00;
        @(posedge sys_clk) sda_cmp <= 7'h02;
        wait_for(2, 8'h02);
        i_remote_isolator.send(3'h3);
        @(posedge sys_clk) sda_cmp <= HIGH;
        wait_for(1, 8'h00);
        wait_for(2, 8'h03);
    endtask : t_remote
    task automatic t_local();
        @(posedge sys_clk) sda_cmp <= LOW;
        wait_for(2, 8'h02);
        @(posedge sys_clk) sda_cmp <= 7'h30;
        wait_for(2, 8'h03);
        check({6'h00, limiter_en}, 8'h01);
        @(posedge sys_clk) sda_cmp <= 7'h31;
        wait_for(2, 8'h02);
        @(posedge sys_clk) sda_cmp <= HIGH;
        wait_for(2, 8'h03);
    endtask : t_local
    task automatic t_retx();
        int n;
        n = seen_cnt;
        repeat (400) @(posedge sys_clk);
        check({7'h00, (seen_cnt - n) >= 2}, 8'h01);
    endtask : t_retx
    task automatic t_stuck();
        @(posedge sys_clk) scl_cmp <= LOW;
        wait_for(0, 8'h00);
        wait_for(2, 8'h05);
        @(posedge sys_clk) scl_cmp <= HIGH;
        relink();
        wait_for(0, 8'h01);
    endtask : t_stuck
    task automatic t_power();
        for (int i = 0; i < 3; i++) begin
            @(posedge sys_clk);
            enable <= (i != 0);
            over_temp <= (i == 1);
            vcc_ok <= (i != 2);
            wait_for(0, 8'h00);
            if (i == 0) wait_for(3, 8'h01);
            @(posedge sys_clk);
            enable <= 1'b1;
            over_temp <= 1'b0;
            vcc_ok <= 1'b1;
            relink();
            wait_for(0, 8'h01);
        end
    endtask : t_power
    initial begin
        rst_n <= 1'b0;
        enable <= 1'b1;
        vcc_ok <= 1'b1;
        over_temp <= 1'b0;
        sda_cmp <= HIGH;
        scl_cmp <= HIGH;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_link();
        t_remote();
        t_local();
        t_retx();
        t_stuck();
        t_power();
        test_done();
    end
endmodule : tb_isolated_i2c_link_bridge
